/* File: decoder_pkg.sv */
// constants shared by the integer instruction decoder and its bench
// assumes word-wide single transfers on an ahb-lite register bus
`default_nettype none
package decoder_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned DEV_NUM_W = 10;
   localparam int unsigned DEV_NUM_LSB = 11;
   localparam int unsigned CTRL_FLOAT_BIT = 0;
   // register byte offsets
   localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_DEV_LIMIT = 32'h0000_0004;
   localparam logic [31:0] OFS_NCOMMIT = 32'h0000_0008;
   localparam logic [31:0] OFS_NEXC = 32'h0000_000C;
   localparam logic CTRL_FLOAT_RST = 1'h0;
   localparam logic [9:0] DEV_LIMIT_RST = 10'h000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;
   // primary opcodes, instruction bits 0:5
   localparam logic [5:0] PRI_TRAP_IMM = 6'h03, PRI_SUB_IMM = 6'h08;
   localparam logic [5:0] PRI_COND_BR = 6'h10, PRI_BRANCH = 6'h12;
   localparam logic [5:0] PRI_XL = 6'h13, PRI_ROT_INS = 6'h14;
   localparam logic [5:0] PRI_ROT_IMM = 6'h15, PRI_ROT_REG = 6'h17;
   localparam logic [5:0] PRI_XOR_IMM = 6'h1A, PRI_XOR_IMM_SH = 6'h1B;
   localparam logic [5:0] PRI_X = 6'h1F, PRI_ST_W = 6'h24;
   localparam logic [5:0] PRI_ST_WU = 6'h25, PRI_ST_H = 6'h2C;
   localparam logic [5:0] PRI_ST_HU = 6'h2D, PRI_ST_MULTI = 6'h2F;
   localparam logic [5:0] PRI_FLOAT_S = 6'h3B, PRI_FLOAT_D = 6'h3F;
   localparam logic [2:0] PRI_FLOAT_MEM = 3'h6;
   // extended opcode groups, instruction bits 26:30
   localparam logic [4:0] LO_ARITH = 5'h08, LO_LOGIC = 5'h1C;
   localparam logic [4:0] LO_ST_IDX = 5'h17, LO_MISC = 5'h16;
   localparam logic [4:0] LO_XLATE = 5'h12, LO_TRAP = 5'h04;
   localparam logic [4:0] LO_SYS = 5'h03, LO_BR_REG = 5'h10;
   localparam logic [4:0] LO_COND = 5'h01, LO_RET = 5'h12;
   localparam logic [4:0] LO_RET_CRIT = 5'h13, LO_RET_DBG = 5'h07;
   localparam logic [4:0] LO_FIELD = 5'h00;
   localparam logic [3:0] SUB_FROM_HI = 4'h1;
   typedef enum logic [6:0] {
      OP_NONE, OP_SUB_FROM, OP_SUB_CARRY, OP_SUB_EXT, OP_SUB_M1_EXT,
      OP_SUB_ZERO_EXT, OP_SUB_IMM_CARRY, OP_NEGATE,
      OP_XOR, OP_XOR_IMM, OP_XOR_IMM_SH, OP_AND, OP_AND_COMPL, OP_OR,
      OP_OR_COMPL, OP_NOR, OP_NAND, OP_EQUIV,
      OP_ROT_INSERT, OP_ROT_IMM_MASK, OP_ROT_REG_MASK,
      OP_ST_WORD, OP_ST_WORD_UPD, OP_ST_HALF, OP_ST_HALF_UPD, OP_ST_MULTI,
      OP_ST_HALF_REV, OP_ST_WORD_REV, OP_ST_WORD_COND,
      OP_XLATE_INVAL, OP_XLATE_READ, OP_XLATE_SEARCH, OP_XLATE_WRITE,
      OP_XLATE_SYNC, OP_TRAP_REGISTER_OP, OP_TRAP_IMM,
      OP_IRQ_EN_REG, OP_IRQ_EN_IMM, OP_BRANCH, OP_CONDITIONAL_BRANCH,
      OP_BR_LINK_REG, OP_BR_COUNT_REG,
      OP_COND_NOR, OP_COND_AND_COMPL, OP_COND_XOR, OP_COND_NAND,
      OP_COND_AND, OP_COND_EQUIV, OP_COND_OR_COMPL, OP_COND_OR,
      OP_RET_IRQ, OP_RET_CRIT, OP_RET_DEBUG, OP_INSN_SYNC, OP_FIELD_MOVE,
      OP_DEV_READ, OP_DEV_WRITE, OP_FLOAT
   } op_e;
endpackage
`default_nettype wire

/* File: integer_instruction_decoder.sv */
// integer instruction decoder with an ahb-lite control/status slave
// assumes fetch logic on sys_clk; one decoded word per cycle, no stall
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`default_nettype none
module integer_instruction_decoder (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic dec_valid,
   output decoder_pkg::op_e dec_op,
   output logic dec_rec_field,
   output logic dec_rec_excess,
   output logic dec_carry_upd,
   output logic dec_indexed,
   output logic dec_absolute,
   output logic dec_save_link,
   output logic exc_invalid_form,
   output logic exc_illegal,
   output logic exc_float_unimpl,
   output logic exc_float_unavail,
   output logic dec_commit
);
   import decoder_pkg::*;

   typedef struct packed {
      op_e op;
      logic rc;
      logic oe;
      logic carry;
      logic idx;
      logic absb;
      logic link;
      logic resv;
      logic need1;
      logic fl;
      logic dev;
      logic known;
   } dec_s;

   typedef struct packed {
      logic float_permit_bit;
      logic [DEV_NUM_W-1:0] dev_limit;
      logic [CNT_W-1:0] n_commit;
      logic [CNT_W-1:0] n_exc;
      logic wr_pend;
      logic [1:0] wr_idx;
      logic ready;
      logic [DATA_W-1:0] rdata;
      logic dv;
      op_e op;
      logic rc;
      logic oe;
      logic carry;
      logic idx;
      logic absb;
      logic link;
      logic inv;
      logic ill;
      logic funimp;
      logic funav;
      logic commit;
   } st_s;

   localparam st_s ST_RST = '{float_permit_bit: CTRL_FLOAT_RST,
      dev_limit: DEV_LIMIT_RST, ready: 1'h1, op: OP_NONE, default: '0};

   st_s st_r;
   st_s st_nxt;
   dec_s d;

   // bit 0 of the manual is the msb: bits 21:30 are word[10:1]
   function automatic dec_s decode(input logic [31:0] w);
      dec_s r;
      logic [4:0] hi;
      logic [4:0] lo;
      r = '{op: OP_NONE, default: '0};
      hi = w[10:6];
      lo = w[5:1];
      r.known = 1'h1;
      case (w[31:26])
         PRI_TRAP_IMM: r.op = OP_TRAP_IMM;
         PRI_SUB_IMM: begin
            r.op = OP_SUB_IMM_CARRY;
            r.carry = 1'h1;
         end
         PRI_BRANCH, PRI_COND_BR: begin
            r.op = (w[31:26] == PRI_BRANCH) ? OP_BRANCH
                                             : OP_CONDITIONAL_BRANCH;
            r.absb = w[1];
            r.link = w[0];
         end
         PRI_ROT_INS, PRI_ROT_IMM, PRI_ROT_REG: begin
            r.op = (w[31:26] == PRI_ROT_INS) ? OP_ROT_INSERT :
                   (w[31:26] == PRI_ROT_IMM) ? OP_ROT_IMM_MASK
                                             : OP_ROT_REG_MASK;
            r.rc = w[0];
         end
         PRI_XOR_IMM: r.op = OP_XOR_IMM;
         PRI_XOR_IMM_SH: r.op = OP_XOR_IMM_SH;
         PRI_ST_W: r.op = OP_ST_WORD;
         PRI_ST_WU: r.op = OP_ST_WORD_UPD;
         PRI_ST_H: r.op = OP_ST_HALF;
         PRI_ST_HU: r.op = OP_ST_HALF_UPD;
         PRI_ST_MULTI: r.op = OP_ST_MULTI;
         PRI_FLOAT_S, PRI_FLOAT_D: begin
            r.op = OP_FLOAT;
            r.fl = 1'h1;
         end
         PRI_XL: begin
            r.resv = 1'h1;
            case (lo)
               LO_BR_REG: begin
                  r.resv = 1'h0;
                  r.link = w[0];
                  case (hi)
                     5'h00: r.op = OP_BR_LINK_REG;
                     5'h10: r.op = OP_BR_COUNT_REG;
                     default: r.known = 1'h0;
                  endcase
               end
               LO_COND: begin
                  case (hi)
                     5'h01: r.op = OP_COND_NOR;
                     5'h04: r.op = OP_COND_AND_COMPL;
                     5'h06: r.op = OP_COND_XOR;
                     5'h07: r.op = OP_COND_NAND;
                     5'h08: r.op = OP_COND_AND;
                     5'h09: r.op = OP_COND_EQUIV;
                     5'h0D: r.op = OP_COND_OR_COMPL;
                     5'h0E: r.op = OP_COND_OR;
                     default: r.known = 1'h0;
                  endcase
               end
               LO_RET: r.op = (hi == 5'h01) ? OP_RET_IRQ : OP_NONE;
               LO_RET_CRIT: r.op = (hi == 5'h01) ? OP_RET_CRIT : OP_NONE;
               LO_RET_DBG: r.op = (hi == 5'h01) ? OP_RET_DEBUG : OP_NONE;
               LO_MISC: r.op = (hi == 5'h04) ? OP_INSN_SYNC : OP_NONE;
               LO_FIELD: r.op = (hi == 5'h00) ? OP_FIELD_MOVE : OP_NONE;
               default: r.known = 1'h0;
            endcase
            if (r.op == OP_NONE) begin
               r.known = 1'h0;
            end
         end
         PRI_X: begin
            r.resv = 1'h1;
            case (lo)
               LO_ARITH: begin
                  r.resv = 1'h0;
                  r.oe = w[10];
                  r.rc = w[0];
                  case (w[9:6])
                     SUB_FROM_HI: r.op = OP_SUB_FROM;
                     4'h0: r.op = OP_SUB_CARRY;
                     4'h4: r.op = OP_SUB_EXT;
                     4'h7: r.op = OP_SUB_M1_EXT;
                     4'h6: r.op = OP_SUB_ZERO_EXT;
                     4'h3: r.op = OP_NEGATE;
                     default: r.known = 1'h0;
                  endcase
                  r.carry = (r.op != OP_SUB_FROM) && (r.op != OP_NEGATE);
               end
               LO_LOGIC: begin
                  r.resv = 1'h0;
                  r.rc = w[0];
                  case (hi)
                     5'h09: r.op = OP_XOR;
                     5'h00: r.op = OP_AND;
                     5'h01: r.op = OP_AND_COMPL;
                     5'h0D: r.op = OP_OR;
                     5'h0C: r.op = OP_OR_COMPL;
                     5'h03: r.op = OP_NOR;
                     5'h0E: r.op = OP_NAND;
                     5'h08: r.op = OP_EQUIV;
                     default: r.known = 1'h0;
                  endcase
               end
               LO_ST_IDX: begin
                  r.idx = 1'h1;
                  case (hi)
                     5'h04: r.op = OP_ST_WORD;
                     5'h05: r.op = OP_ST_WORD_UPD;
                     5'h0C: r.op = OP_ST_HALF;
                     5'h0D: r.op = OP_ST_HALF_UPD;
                     default: r.known = 1'h0;
                  endcase
               end
               LO_MISC: begin
                  // only the stores here are indexed, not the buffer sync
                  r.idx = (hi == 5'h1C) || (hi == 5'h14) || (hi == 5'h04);
                  case (hi)
                     5'h1C: r.op = OP_ST_HALF_REV;
                     5'h14: r.op = OP_ST_WORD_REV;
                     5'h04: begin
                        r.op = OP_ST_WORD_COND;
                        r.resv = 1'h0;
                        r.need1 = 1'h1;
                        r.rc = 1'h1;
                     end
                     5'h11: r.op = OP_XLATE_SYNC;
                     default: r.known = 1'h0;
                  endcase
               end
               LO_XLATE: begin
                  case (hi)
                     5'h18: r.op = OP_XLATE_INVAL;
                     5'h1D: r.op = OP_XLATE_READ;
                     5'h1E: r.op = OP_XLATE_WRITE;
                     5'h1C: begin
                        r.op = OP_XLATE_SEARCH;
                        r.resv = 1'h0;
                     end
                     default: r.known = 1'h0;
                  endcase
               end
               LO_TRAP: begin
                  r.op = (hi == 5'h00) ? OP_TRAP_REGISTER_OP : OP_NONE;
               end
               LO_SYS: begin
                  case (hi)
                     5'h04: r.op = OP_IRQ_EN_REG;
                     5'h05: r.op = OP_IRQ_EN_IMM;
                     5'h0A, 5'h08: r.op = OP_DEV_READ;
                     5'h0E, 5'h0C: r.op = OP_DEV_WRITE;
                     default: r.known = 1'h0;
                  endcase
                  r.dev = (r.op == OP_DEV_READ) || (r.op == OP_DEV_WRITE);
               end
               default: r.known = 1'h0;
            endcase
            if (r.op == OP_NONE) begin
               r.known = 1'h0;
            end
         end
         default: begin
            // float loads and stores share the top three primary bits
            r.fl = (w[31:29] == PRI_FLOAT_MEM);
            r.op = r.fl ? OP_FLOAT : OP_NONE;
            r.known = r.fl;
         end
      endcase
      return r;
   endfunction

   function automatic logic [DATA_W-1:0] reg_read(input logic [31:0] a,
                                                  input st_s s);
      logic [DATA_W-1:0] v;
      v = '0;
      case (a)
         OFS_CTRL: v[CTRL_FLOAT_BIT] = s.float_permit_bit;
         OFS_DEV_LIMIT: v[DEV_NUM_W-1:0] = s.dev_limit;
         OFS_NCOMMIT: v[CNT_W-1:0] = s.n_commit;
         OFS_NEXC: v[CNT_W-1:0] = s.n_exc;
         default: v = '0;
      endcase
      return v;
   endfunction

   always_comb begin
      logic acc;
      logic wok;
      logic bad;
      acc = hsel && hready && (htrans == HTRANS_NONSEQ);
      wok = (hsize == HSIZE_WORD);
      st_nxt = st_r;
      st_nxt.ready = 1'h1;
      // data phase of a write lands first, so a read right behind sees it
      if (st_r.wr_pend) begin
         case (st_r.wr_idx)
            OFS_CTRL[3:2]:
               st_nxt.float_permit_bit = hwdata[CTRL_FLOAT_BIT];
            OFS_DEV_LIMIT[3:2]: st_nxt.dev_limit = hwdata[DEV_NUM_W-1:0];
            default: st_nxt.wr_idx = st_r.wr_idx;
         endcase
      end
      st_nxt.wr_pend = acc && hwrite && wok;
      st_nxt.wr_idx = haddr[3:2];
      if (acc && !hwrite) begin
         st_nxt.rdata = reg_read(haddr, st_nxt);
      end
      d = decode(instr_word);
      st_nxt.dv = instr_valid;
      st_nxt.op = d.op;
      st_nxt.rc = d.rc;
      st_nxt.oe = d.oe;
      st_nxt.carry = d.carry;
      st_nxt.idx = d.idx;
      st_nxt.absb = d.absb;
      st_nxt.link = d.link;
      st_nxt.inv = instr_valid && d.known && !d.fl
                   && ((d.resv && instr_word[0])
                       || (d.need1 && !instr_word[0]));
      // float permit is taken from the settled register, not the bus
      st_nxt.funimp = instr_valid && d.fl && st_r.float_permit_bit;
      st_nxt.funav = instr_valid && d.fl && !st_r.float_permit_bit;
      st_nxt.ill = instr_valid && (!d.known
                   || (d.dev && (instr_word[DEV_NUM_LSB+DEV_NUM_W-1:DEV_NUM_LSB]
                                 >= st_r.dev_limit)));
      bad = st_nxt.inv || st_nxt.ill || st_nxt.funimp || st_nxt.funav;
      st_nxt.commit = instr_valid && !bad;
      if (st_nxt.commit) begin
         st_nxt.n_commit = st_r.n_commit + 1'h1;
      end
      if (instr_valid && bad) begin
         st_nxt.n_exc = st_r.n_exc + 1'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = st_r.ready;
   assign hresp = HRESP_OKAY;
   assign hrdata = st_r.rdata;
   assign dec_valid = st_r.dv;
   assign dec_op = st_r.op;
   assign dec_rec_field = st_r.rc;
   assign dec_rec_excess = st_r.oe;
   assign dec_carry_upd = st_r.carry;
   assign dec_indexed = st_r.idx;
   assign dec_absolute = st_r.absb;
   assign dec_save_link = st_r.link;
   assign exc_invalid_form = st_r.inv;
   assign exc_illegal = st_r.ill;
   assign exc_float_unimpl = st_r.funimp;
   assign exc_float_unavail = st_r.funav;
   assign dec_commit = st_r.commit;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_ctl_set;
      hsel && hready && htrans == HTRANS_NONSEQ && hwrite
      && hsize == HSIZE_WORD && haddr == OFS_CTRL
      ##1 hwdata[CTRL_FLOAT_BIT];
   endsequence
   sequence s_branch_in;
      instr_valid && instr_word[31:26] == PRI_BRANCH;
   endsequence

   property p_resv;
      instr_valid && instr_word[31:26] == PRI_X
      && instr_word[5:1] == LO_ST_IDX && instr_word[0]
      |=> exc_invalid_form && !dec_commit;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit accepted");

   property p_float;
      instr_valid && instr_word[31:26] == PRI_FLOAT_D |=>
      exc_float_unimpl == $past(st_r.float_permit_bit)
      && exc_float_unavail == !$past(st_r.float_permit_bit);
   endproperty
   a_float: assert property (p_float) else $error("float trap kind wrong");

   property p_ctl_steers;
      s_ctl_set ##1 (instr_valid && instr_word[31:26] == PRI_FLOAT_D)
      |=> exc_float_unimpl && !dec_commit;
   endproperty
   a_ctl_steers: assert property (p_ctl_steers) else $error("permit ignored");

   property p_dev;
      dec_valid && (dec_op == OP_DEV_READ || dec_op == OP_DEV_WRITE) |->
      exc_illegal == ($past(instr_word[DEV_NUM_LSB+DEV_NUM_W-1:DEV_NUM_LSB])
                      >= $past(st_r.dev_limit));
   endproperty
   a_dev: assert property (p_dev) else $error("device number check");

   property p_sub_from;
      instr_valid && instr_word[31:26] == PRI_X
      && instr_word[9:1] == {SUB_FROM_HI, LO_ARITH} |=>
      dec_op == OP_SUB_FROM && dec_rec_field == $past(instr_word[0]);
   endproperty
   a_sub_from: assert property (p_sub_from) else $error("subtract-from");

   property p_excess;
      dec_valid && dec_op inside {OP_SUB_FROM, OP_SUB_CARRY, OP_SUB_EXT,
                                  OP_SUB_M1_EXT, OP_SUB_ZERO_EXT}
      |-> dec_rec_excess == $past(instr_word[10]);
   endproperty
   a_excess: assert property (p_excess) else $error("excess variant");

   property p_sub_imm;
      instr_valid && instr_word[31:26] == PRI_SUB_IMM |=>
      dec_op == OP_SUB_IMM_CARRY && dec_carry_upd && dec_commit;
   endproperty
   a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract");

   property p_st_cond;
      dec_valid && dec_op == OP_ST_WORD_COND |->
      dec_rec_field && (exc_invalid_form == !$past(instr_word[0]));
   endproperty
   a_st_cond: assert property (p_st_cond) else $error("conditional store");

   property p_search;
      dec_valid && dec_op == OP_XLATE_SEARCH |-> !exc_invalid_form;
   endproperty
   a_search: assert property (p_search) else $error("search bit rejected");

   property p_branch;
      s_branch_in |=> dec_op == OP_BRANCH && dec_commit
      && dec_absolute == $past(instr_word[1])
      && dec_save_link == $past(instr_word[0]);
   endproperty
   a_branch: assert property (p_branch) else $error("branch bits wrong");

   property p_unknown;
      dec_valid && exc_illegal |-> !dec_commit
      && st_r.n_commit == $past(st_r.n_commit);
   endproperty
   a_unknown: assert property (p_unknown) else $error("illegal committed");
endmodule
`default_nettype wire

/* File: fetch_model.sv */
// fetch stage model: hands queued words to the decoder, one per cycle
// assumes the bench queues words through put(); no stall exists
`default_nettype none
module fetch_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   output logic instr_valid,
   output logic [31:0] instr_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] pend[$];
   task automatic put(input logic [31:0] word);
      pend.push_back(word);
   endtask
   // idle word lines flip every cycle so stale data is never mistaken
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         instr_valid <= 1'h0;
         instr_word <= 32'h0000_0000;
      end else if (pend.size() > 0) begin
         instr_valid <= 1'h1;
         instr_word <= pend.pop_front();
      end else begin
         instr_valid <= 1'h0;
         instr_word <= ~instr_word;
      end
   end
endmodule
`default_nettype wire

/* File: integer_instruction_decoder_test.sv */
// self-checking bench: decode table, trap flags and the register slave
// assumes decoder_pkg and fetch_model are compiled before this file
`default_nettype none
module integer_instruction_decoder_test;
   import decoder_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, instr_word;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = HSIZE_WORD;
   logic hreadyout, hresp, instr_valid, dec_valid, dec_rec_field;
   logic dec_rec_excess, dec_carry_upd, dec_indexed, dec_absolute;
   logic dec_save_link, exc_invalid_form, exc_illegal, exc_float_unimpl;
   logic exc_float_unavail, dec_commit;
   logic [10:0] flags;
   logic [15:0] n_ok = 16'h0, n_exc = 16'h0;
   op_e dec_op;
   int n_errors = 0, compares = 0;
   assign flags = {dec_rec_field, dec_rec_excess, dec_carry_upd, dec_indexed,
      dec_absolute, dec_save_link, exc_invalid_form, exc_illegal,
      exc_float_unimpl, exc_float_unavail, dec_commit};
   fetch_model fetch_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr_word(instr_word));
   integer_instruction_decoder dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr_word(instr_word), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .dec_valid(dec_valid), .dec_op(dec_op),
      .dec_rec_field(dec_rec_field), .dec_rec_excess(dec_rec_excess),
      .dec_carry_upd(dec_carry_upd), .dec_indexed(dec_indexed),
      .dec_absolute(dec_absolute), .dec_save_link(dec_save_link),
      .exc_invalid_form(exc_invalid_form), .exc_illegal(exc_illegal),
      .exc_float_unimpl(exc_float_unimpl),
      .exc_float_unavail(exc_float_unavail), .dec_commit(dec_commit));
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic stop_test();
      $display("counts: %0d compares, %0d mismatches", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // ready is looked at 1ns after a rising edge, where it equals its value at the next edge
   task automatic wait_rdy();
      int n;
      n = 0;
      while (hreadyout !== 1'h1) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (n > 50) begin
            chk("hready wait", 32'h1, 32'h0);
            stop_test();
         end
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, d);
      @(posedge sys_clk);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      #1;
      wait_rdy();
      @(posedge sys_clk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      #1;
      wait_rdy();
      // read data is taken at the edge that closes the data phase
      @(posedge sys_clk);
      rd = hrdata;
      chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
      #1;
   endtask
   task automatic rchk(input logic [31:0] a, exp);
      bus(1'h0, a, 32'h0);
      chk("register read", exp, rd);
   endtask
   function automatic logic [31:0] w(logic [5:0] p, logic [4:0] h, l,
         logic b);
      return {p, 15'h0000, h, l, b};
   endfunction
   task automatic look(input op_e op, input logic [10:0] f, input logic full);
      chk("dec_valid", 32'h1, {31'h0, dec_valid});
      if (full) begin
         chk("dec_op", {25'h0, op}, {25'h0, dec_op});
         chk("flags", {21'h0, f}, {21'h0, flags});
      end else begin
         chk("exception flags", {27'h0, f[4:0]}, {27'h0, flags[4:0]});
      end
      if (f[0]) begin
         n_ok++;
      end else begin
         n_exc++;
      end
   endtask
   task automatic d(input logic [31:0] word, input op_e op,
         input logic [10:0] f, input logic full = 1'h1);
      fetch_u.put(word);
      repeat (2) @(posedge sys_clk);
      #1;
      look(op, f, full);
   endtask
   // list runs from the low end; prim puts the codes in the primary field
   task automatic run(input logic [5:0] p, input logic [4:0] lo,
         input logic [39:0] hs, input int n, input op_e op0,
         input logic [10:0] f, input logic prim);
      logic [4:0] h;
      for (int i = 0; i < n; i++) begin
         h = hs[5*i +: 5];
         d(prim ? w({p[5], h}, 5'h00, 5'h00, 1'h0) : w(p, h, lo, 1'h0),
            op_e'(op0 + i), f);
      end
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'h0;
      #1;
      rchk(OFS_CTRL, 32'h0);
      rchk(OFS_DEV_LIMIT, 32'h0);
      rchk(OFS_NEXC, 32'h0);
      rchk(32'h0000_0010, 32'h0);
      $display("test registers done");
      d(w(6'h1F, 5'h01, 5'h08, 1'h0), OP_SUB_FROM, 11'h001);
      d(w(6'h1F, 5'h01, 5'h08, 1'h1), OP_SUB_FROM, 11'h401);
      run(6'h1F, 5'h08, {5'h06, 5'h07, 5'h04, 5'h00}, 4, OP_SUB_CARRY,
         11'h101, 1'h0);
      d(w(6'h1F, 5'h10, 5'h08, 1'h0), OP_SUB_CARRY, 11'h301);
      d(w(6'h1F, 5'h14, 5'h08, 1'h1), OP_SUB_EXT, 11'h701);
      d(w(6'h08, 5'h00, 5'h00, 1'h0), OP_SUB_IMM_CARRY, 11'h101);
      run(6'h20, 5'h00, {5'h0F, 5'h0D, 5'h0C, 5'h05, 5'h04}, 5, OP_ST_WORD,
         11'h001, 1'h1);
      run(6'h1F, 5'h17, {5'h0D, 5'h0C, 5'h05, 5'h04}, 4, OP_ST_WORD,
         11'h081, 1'h0);
      d(w(6'h1F, 5'h1C, 5'h16, 1'h0), OP_ST_HALF_REV, 11'h081);
      d(w(6'h1F, 5'h14, 5'h16, 1'h0), OP_ST_WORD_REV, 11'h081);
      d(w(6'h1F, 5'h04, 5'h16, 1'h1), OP_ST_WORD_COND, 11'h481);
      d(w(6'h1F, 5'h04, 5'h16, 1'h0), OP_NONE, 11'h010, 1'h0);
      run(6'h1F, 5'h12, {5'h1E, 5'h1C, 5'h1D, 5'h18}, 4, OP_XLATE_INVAL,
         11'h001, 1'h0);
      d(w(6'h1F, 5'h11, 5'h16, 1'h0), OP_XLATE_SYNC, 11'h001);
      d(w(6'h1F, 5'h1C, 5'h12, 1'h1), OP_XLATE_SEARCH, 11'h001);
      d(w(6'h1F, 5'h18, 5'h12, 1'h1), OP_NONE, 11'h010, 1'h0);
      d(w(6'h1F, 5'h00, 5'h04, 1'h0), OP_TRAP_REGISTER_OP,
         11'h001);
      d(w(6'h03, 5'h00, 5'h00, 1'h0), OP_TRAP_IMM, 11'h001);
      run(6'h1F, 5'h03, {5'h05, 5'h04}, 2, OP_IRQ_EN_REG, 11'h001,
         1'h0);
      d(w(6'h1F, 5'h09, 5'h1C, 1'h1), OP_XOR, 11'h401);
      run(6'h00, 5'h00, {5'h1B, 5'h1A}, 2, OP_XOR_IMM, 11'h001,
         1'h1);
      d(w(6'h12, 5'h00, 5'h01, 1'h1), OP_BRANCH, 11'h061);
      d(w(6'h10, 5'h00, 5'h00, 1'h0), OP_CONDITIONAL_BRANCH,
         11'h001);
      d(w(6'h13, 5'h00, 5'h10, 1'h1), OP_BR_LINK_REG, 11'h021);
      d(w(6'h13, 5'h10, 5'h10, 1'h0), OP_BR_COUNT_REG, 11'h001);
      run(6'h13, 5'h01, {5'h0E, 5'h0D, 5'h09, 5'h08, 5'h07, 5'h06, 5'h04,
         5'h01}, 8, OP_COND_NOR, 11'h001, 1'h0);
      run(6'h13, 5'h12, {5'h01}, 1, OP_RET_IRQ, 11'h001, 1'h0);
      d(w(6'h13, 5'h01, 5'h13, 1'h0), OP_RET_CRIT, 11'h001);
      d(w(6'h13, 5'h01, 5'h07, 1'h0), OP_RET_DEBUG, 11'h001);
      d(w(6'h13, 5'h04, 5'h16, 1'h0), OP_INSN_SYNC, 11'h001);
      d(w(6'h13, 5'h00, 5'h00, 1'h0), OP_FIELD_MOVE, 11'h001);
      run(6'h00, 5'h00, {5'h17, 5'h15, 5'h14}, 3, OP_ROT_INSERT, 11'h001,
         1'h1);
      d(w(6'h1F, 5'h1F, 5'h1F, 1'h0), OP_NONE, 11'h008, 1'h0);
      d(w(6'h01, 5'h00, 5'h00, 1'h0), OP_NONE, 11'h008, 1'h0);
      $display("test decode table done");
      d(w(6'h3F, 5'h00, 5'h15, 1'h0), OP_FLOAT, 11'h002, 1'h0);
      bus(1'h1, OFS_CTRL, 32'h1);
      d(w(6'h3B, 5'h00, 5'h15, 1'h0), OP_FLOAT, 11'h004, 1'h0);
      d(w(6'h1F, 5'h0A, 5'h03, 1'h0) | 32'h1800, OP_NONE, 11'h008,
         1'h0);
      bus(1'h1, OFS_DEV_LIMIT, 32'h4);
      d(w(6'h1F, 5'h0A, 5'h03, 1'h0) | 32'h1800, OP_DEV_READ,
         11'h001);
      d(w(6'h1F, 5'h0E, 5'h03, 1'h0) | 32'h2000, OP_NONE, 11'h008,
         1'h0);
      // back to back words: one decode per cycle, no bubble
      fetch_u.put(w(6'h1F, 5'h09, 5'h1C, 1'h0));
      fetch_u.put(w(6'h1F, 5'h18, 5'h12, 1'h1));
      repeat (2) @(posedge sys_clk);
      #1;
      look(OP_XOR, 11'h001, 1'h1);
      @(posedge sys_clk);
      #1;
      look(OP_NONE, 11'h010, 1'h0);
      bus(1'h1, OFS_NCOMMIT, 32'hFFFF);
      rchk(OFS_NCOMMIT, {16'h0, n_ok});
      rchk(OFS_NEXC, {16'h0, n_exc});
      $display("test traps and counters done");
      stop_test();
   end
endmodule
`default_nettype wire
